/* File: hdl/pwmdb_pkg.sv */
package pwmdb_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0  = 8'h00; // first_control_register
  localparam logic [7:0] ADDR_CTRL1  = 8'h04; // second_control_register
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_WIDTH  = 8'h0c; // duty_compare_register
  localparam logic [7:0] ADDR_COUNT  = 8'h10; // count_value_register, read only
  localparam logic [7:0] ADDR_STATUS = 8'h14; // read only

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL0_EN      = 0;
  localparam int CTRL0_HWTRIG  = 1;
  localparam int CTRL0_IRQSEL  = 2;
  localparam int CTRL0_IRQEN   = 3;
  localparam int CTRL0_SHOT_LO = 4;
  localparam int CTRL1_DT_LO   = 0;
  localparam int CTRL1_KM_LO   = 4;

  // ---------------------------------------------------------------------------
  // reset values and widths
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] WIDTH_RST  = 8'h7f;
  localparam logic [7:0] ZERO8      = 8'h00;
  localparam logic [7:0] ONE8       = 8'h01;
  localparam logic [3:0] ZERO4      = 4'h0;
  localparam logic [3:0] ONE4       = 4'h1;
  localparam logic [6:0] ZERO7      = 7'h00;
  localparam logic [6:0] ONE7       = 7'h01;

  typedef enum logic [1:0] {
    PWMDB_KILL_SYNC    = 2'h0, // edge_restart_shutdown_mode
    PWMDB_KILL_ASYNC   = 2'h1, // free_running_shutdown_mode
    PWMDB_KILL_DISABLE = 2'h2  // full_stop_shutdown_mode
  } pwmdb_kill_e;

  // dead band state, gray coded along idle -> rise wait -> fall wait
  typedef enum logic [1:0] {
    PWMDB_DB_IDLE = 2'b00,
    PWMDB_DB_RISE = 2'b01,
    PWMDB_DB_FALL = 2'b11
  } pwmdb_db_e;

  typedef struct packed {
    logic       enable;
    logic       hw_trig;
    logic       irq_sel;   // 0: lead rising edge, 1: kill
    logic       irq_en;
    logic [3:0] shot_count_field;
  } pwmdb_ctrl0_s;

  typedef struct packed {
    logic [2:0]  dead_code;
    pwmdb_kill_e kill_mode;
  } pwmdb_ctrl1_s;

  typedef struct packed {
    pwmdb_ctrl0_s ctrl0;
    pwmdb_ctrl1_s ctrl1;
    logic [7:0]   period;
    logic [7:0]   width_buf;
    logic [7:0]   width_live;
    logic         width_pend;
    logic [7:0]   count;
    logic [3:0]   shots_left;
    logic         halted;     // ppg last shot reached
    logic         ref_q;      // compare reference
    logic         ref_d;      // sampled reference for edge detect
    pwmdb_db_e    db_state;
    logic [6:0]   dead_cnt;
    logic         lead;       // raw lead, registered on the rising clock edge
    logic         lag;
    logic         kill_q;
    logic         irq;
    logic [31:0]  prdata;
  } pwmdb_state_s;

  // dead time code to clock count, 0 disables the gap
  function automatic logic [6:0] pwmdb_dead_len(input logic [2:0] code);
    logic [6:0] r;
    r = ZERO7;
    if (code != 3'h0) begin
      r = ONE7 << (code - 3'h1);
    end
    return r;
  endfunction : pwmdb_dead_len

endpackage : pwmdb_pkg

/* File: hdl/pwmdb_core.sv */
// Functional notes
// - running counter decrements each clock
// - reload period after terminal count
// - period write while stopped loads counter
// - dead code write while stopped loads countdown
// - stopped block drives both outputs low
// - start input low freezes the counter and compare
// - reference high after compare, low after reload
// - width equal period keeps reference high
// - one interrupt, lead rise or kill, enabled
// - rising reference: lag low, delay, lead high
// - falling reference: lead low, delay, lag high
// - outputs track reference minus dead time
// - three bit code picks 0..64 clocks
// - kill forces outputs low asynchronously
// - sync restart: hold reset, wait edge
// - async restart: state runs, delayed restore
// - disable kill stops block, software re-enables
// - nonzero shot count stops after last shot in software trigger mode
// - compare uses strict greater than
// - running width writes are buffered
// - no gate input, no terminal count output
// - kill leaves counter alone except disable
// - zero dead time removes the gap
// - software or hardware trigger starts block
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none

module pwmdb_core
  import pwmdb_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // control inputs
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic        kill,
  // drive outputs
  output logic             lead_drive_pin,
  output logic             lag_drive_pin,
  output logic             irq
);

  pwmdb_state_s s_reg;
  pwmdb_state_s s_next;
  logic         lead_neg_reg;
  logic         lag_neg_reg;
  logic         restore_reg;

  logic wr;
  logic rd;
  logic run;
  logic tc;
  logic ref_rise;
  logic ref_fall;
  logic kill_rise;

  // ---------------------------------------------------------------------------
  // apb decode, zero wait states
  // ---------------------------------------------------------------------------
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = s_reg.prdata;

  // the start pin gates the counter in software and hardware trigger mode alike
  assign run = s_reg.ctrl0.enable && !s_reg.halted && start;
  assign tc  = (s_reg.count == ZERO8);
  assign ref_rise  = s_reg.ref_q && !s_reg.ref_d;
  assign ref_fall  = !s_reg.ref_q && s_reg.ref_d;
  assign kill_rise = kill && !s_reg.kill_q;

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.kill_q = kill;
    s_next.irq = 1'b0;

    if (rd) begin
      case (paddr)
        ADDR_CTRL0:  s_next.prdata = {24'h000000, s_reg.ctrl0.shot_count_field, s_reg.ctrl0.irq_en,
                                      s_reg.ctrl0.irq_sel, s_reg.ctrl0.hw_trig, s_reg.ctrl0.enable};
        ADDR_CTRL1:  s_next.prdata = {26'h0000000, s_reg.ctrl1.kill_mode, 1'b0, s_reg.ctrl1.dead_code};
        ADDR_PERIOD: s_next.prdata = {24'h000000, s_reg.period};
        ADDR_WIDTH:  s_next.prdata = {24'h000000, s_reg.width_buf};
        ADDR_COUNT:  s_next.prdata = {24'h000000, s_reg.count};
        ADDR_STATUS: s_next.prdata = {24'h000000, s_reg.shots_left, s_reg.halted, s_reg.ref_q,
                                      s_reg.lag, s_reg.lead};
        default:     s_next.prdata = 32'h00000000;
      endcase
    end

    // counter and compare
    if (run) begin
      if (tc) begin
        s_next.count = s_reg.period;
        if (s_reg.width_pend) begin
          s_next.width_live = s_reg.width_buf;
          s_next.width_pend = 1'b0;
        end
        if (s_reg.ctrl0.shot_count_field != ZERO4 && !s_reg.ctrl0.hw_trig) begin
          if (s_reg.shots_left <= ONE4) begin
            s_next.halted = 1'b1;
          end else begin
            s_next.shots_left = s_reg.shots_left - ONE4;
          end
        end
      end else begin
        s_next.count = s_reg.count - ONE8;
      end
      // reference high unless counter is above width; the reloaded count fails the
      s_next.ref_q = !(s_reg.count > s_reg.width_live);
      if (s_reg.width_live == s_reg.period) begin
        s_next.ref_q = 1'b1;
      end
    end else if (!s_reg.ctrl0.enable) begin
      s_next.ref_q = 1'b0;
    end

    // dead band generator
    s_next.ref_d = s_reg.ref_q;
    if (!s_reg.ctrl0.enable) begin
      s_next.lead = 1'b0;
      s_next.lag = 1'b0;
      s_next.db_state = PWMDB_DB_IDLE;
    end else if (kill && s_reg.ctrl1.kill_mode == PWMDB_KILL_SYNC) begin
      s_next.db_state = PWMDB_DB_IDLE;
      s_next.dead_cnt = pwmdb_dead_len(s_reg.ctrl1.dead_code);
      s_next.lead = 1'b0;
      s_next.lag = 1'b0;
      s_next.ref_d = s_reg.ref_q;
    end else begin
      if (ref_rise) begin
        s_next.lag = 1'b0;
        s_next.dead_cnt = pwmdb_dead_len(s_reg.ctrl1.dead_code);
        s_next.db_state = PWMDB_DB_RISE;
        if (s_reg.ctrl1.dead_code == 3'h0) begin
          s_next.lead = 1'b1;
          s_next.db_state = PWMDB_DB_IDLE;
        end
      end else if (ref_fall) begin
        s_next.lead = 1'b0;
        s_next.dead_cnt = pwmdb_dead_len(s_reg.ctrl1.dead_code);
        s_next.db_state = PWMDB_DB_FALL;
        if (s_reg.ctrl1.dead_code == 3'h0) begin
          s_next.lag = 1'b1;
          s_next.db_state = PWMDB_DB_IDLE;
        end
      end else begin
        case (s_reg.db_state)
          PWMDB_DB_RISE: begin
            if (s_reg.dead_cnt <= ONE7) begin
              s_next.lead = 1'b1;
              s_next.db_state = PWMDB_DB_IDLE;
            end
            s_next.dead_cnt = s_reg.dead_cnt - ONE7;
          end
          PWMDB_DB_FALL: begin
            if (s_reg.dead_cnt <= ONE7) begin
              s_next.lag = 1'b1;
              s_next.db_state = PWMDB_DB_IDLE;
            end
            s_next.dead_cnt = s_reg.dead_cnt - ONE7;
          end
          PWMDB_DB_IDLE: begin
          end
          default: s_next.db_state = PWMDB_DB_IDLE;
        endcase
      end
    end

    // kill in disable mode stops the whole function
    if (kill && s_reg.ctrl1.kill_mode == PWMDB_KILL_DISABLE) begin
      s_next.ctrl0.enable = 1'b0;
      s_next.lead = 1'b0;
      s_next.lag = 1'b0;
    end

    // interrupt pulse
    if (s_reg.ctrl0.irq_en) begin
      if (s_reg.ctrl0.irq_sel) begin
        s_next.irq = kill_rise;
      end else begin
        s_next.irq = s_next.lead && !s_reg.lead;
      end
    end

    // register writes
    if (wr) begin
      case (paddr)
        ADDR_CTRL0: begin
          s_next.ctrl0.hw_trig = pwdata[CTRL0_HWTRIG];
          s_next.ctrl0.irq_sel = pwdata[CTRL0_IRQSEL];
          s_next.ctrl0.irq_en = pwdata[CTRL0_IRQEN];
          s_next.ctrl0.shot_count_field = pwdata[CTRL0_SHOT_LO +: 4];
          if (pwdata[CTRL0_EN]) begin
            s_next.ctrl0.enable = 1'b1; // software start resumes ppg
            // a last shot landing in the same cycle still halts
            s_next.halted = s_next.halted && !s_reg.halted;
            s_next.shots_left = pwdata[CTRL0_SHOT_LO +: 4];
          end else begin
            s_next.ctrl0.enable = 1'b0;
          end
        end
        ADDR_CTRL1: begin
          s_next.ctrl1.dead_code = pwdata[CTRL1_DT_LO +: 3];
          s_next.ctrl1.kill_mode = pwmdb_kill_e'(pwdata[CTRL1_KM_LO +: 2]);
          if (!s_reg.ctrl0.enable) begin
            s_next.dead_cnt = pwmdb_dead_len(pwdata[CTRL1_DT_LO +: 3]);
          end
        end
        ADDR_PERIOD: begin
          s_next.period = pwdata[7:0];
          if (!s_reg.ctrl0.enable) begin
            s_next.count = pwdata[7:0];
          end
        end
        ADDR_WIDTH: begin
          s_next.width_buf = pwdata[7:0];
          if (s_reg.ctrl0.enable) begin
            s_next.width_pend = 1'b1;
          end else begin
            s_next.width_live = pwdata[7:0];
            s_next.width_pend = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // a start written while a full stop kill is up loses to the kill
    if (kill && s_reg.ctrl1.kill_mode == PWMDB_KILL_DISABLE) begin
      s_next.ctrl0.enable = 1'b0;
    end

    // hardware start in hardware trigger mode clears the ppg halt
    if (start && s_reg.ctrl0.hw_trig && s_reg.halted) begin
      s_next.halted = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // state register; clock enable freezes all state
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{ctrl0: '{enable: 1'b0, hw_trig: 1'b0, irq_sel: 1'b0, irq_en: 1'b0,
                          shot_count_field: 4'h0},
                 ctrl1: '{dead_code: 3'h0, kill_mode: PWMDB_KILL_SYNC},
                 period: PERIOD_RST, width_buf: WIDTH_RST, width_live: WIDTH_RST,
                 width_pend: 1'b0, count: PERIOD_RST, shots_left: 4'h0, halted: 1'b0,
                 ref_q: 1'b0, ref_d: 1'b0, db_state: PWMDB_DB_IDLE, dead_cnt: 7'h00,
                 lead: 1'b0, lag: 1'b0, kill_q: 1'b0, irq: 1'b0, prdata: 32'h00000000};
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // outputs are set on the falling clock edge after the countdown
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_neg_reg <= 1'b0;
      lag_neg_reg  <= 1'b0;
      restore_reg  <= 1'b0;
    end else if (clk_en) begin
      lead_neg_reg <= s_reg.lead;
      lag_neg_reg  <= s_reg.lag;
      // restore after kill only once a falling edge has seen kill low
      restore_reg  <= !kill && !s_reg.kill_q;
    end
  end

  // kill gates the pins asynchronously, dead time value is untouched
  // stopping drops the pins at once rather than one clock later
  assign lead_drive_pin = lead_neg_reg && s_reg.lead && !kill && restore_reg && s_reg.ctrl0.enable;
  assign lag_drive_pin  = lag_neg_reg && s_reg.lag && !kill && restore_reg && s_reg.ctrl0.enable;
  assign irq = s_reg.irq;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_count_reload: assert property (clk_en && run && tc |=> s_reg.count == $past(s_reg.period))
    else $error("counter did not reload period");
  a_count_dec: assert property (clk_en && run && !tc && !wr |=> s_reg.count == $past(s_reg.count) - ONE8)
    else $error("counter did not decrement");
  a_kill_low: assert property (kill |-> !lead_drive_pin && !lag_drive_pin)
    else $error("outputs not low under kill");
  a_stop_low: assert property (!s_reg.ctrl0.enable |-> !lead_drive_pin && !lag_drive_pin)
    else $error("outputs not low while stopped");
  a_freeze_start: assert property (clk_en && !start && !wr && s_reg.ctrl0.enable |=> $stable(s_reg.count))
    else $error("counter moved with start low");
  a_no_overlap: assert property (!(s_reg.lead && s_reg.lag))
    else $error("lead and lag overlap");
  a_disable_kill: assert property (clk_en && kill && s_reg.ctrl1.kill_mode == PWMDB_KILL_DISABLE |=> !s_reg.ctrl0.enable)
    else $error("disable kill did not stop block");
  a_sync_hold: assert property (clk_en && kill && s_reg.ctrl0.enable && s_reg.ctrl1.kill_mode == PWMDB_KILL_SYNC
                                |=> s_reg.db_state == PWMDB_DB_IDLE)
    else $error("sync kill did not hold dead band");

  // ---------------------------------------------------------------------------
  // counter, compare and register assertions
  // ---------------------------------------------------------------------------
  a_ref_compare: assert property (clk_en && run |=> s_reg.ref_q == (($past(s_reg.count) <= $past(s_reg.width_live))
                                  || ($past(s_reg.width_live) == $past(s_reg.period))))
    else $error("reference does not follow compare");

  a_ref_full: assert property (clk_en && run && s_reg.width_live == s_reg.period |=> s_reg.ref_q)
    else $error("reference low with width equal period");

  a_period_load: assert property (clk_en && wr && paddr == ADDR_PERIOD && !s_reg.ctrl0.enable
                                  |=> s_reg.count == $past(pwdata[7:0]))
    else $error("stopped period write did not load counter");

  a_dead_load: assert property (clk_en && wr && paddr == ADDR_CTRL1 && !s_reg.ctrl0.enable
                                |=> (($past(pwdata[2:0]) == 3'h0) ? (s_reg.dead_cnt == ZERO7)
                                                                  : $onehot(s_reg.dead_cnt)))
    else $error("stopped dead code write did not load countdown");

  a_width_buffered: assert property (clk_en && wr && paddr == ADDR_WIDTH && s_reg.ctrl0.enable && !(run && tc)
                                     |=> $stable(s_reg.width_live))
    else $error("running width write reached live compare");

  a_ppg_halt: assert property (clk_en && run && tc && s_reg.ctrl0.shot_count_field != ZERO4
                               && !s_reg.ctrl0.hw_trig && s_reg.shots_left <= ONE4 |=> s_reg.halted)
    else $error("last shot did not halt counter");

  a_halt_parked: assert property (clk_en && s_reg.halted && !wr |=> $stable(s_reg.count))
    else $error("halted counter moved");

  // ---------------------------------------------------------------------------
  // dead band assertions
  // ---------------------------------------------------------------------------
  sequence rise_gap_start;
    clk_en && s_reg.ctrl0.enable && !kill && ref_rise && s_reg.ctrl1.dead_code == 3'h1;
  endsequence

  sequence fall_gap_start;
    clk_en && s_reg.ctrl0.enable && !kill && ref_fall && s_reg.ctrl1.dead_code == 3'h1;
  endsequence

  sequence gap_quiet;
    clk_en && s_reg.ctrl0.enable && !kill && !ref_rise && !ref_fall;
  endsequence

  a_rise_lag: assert property (clk_en && s_reg.ctrl0.enable && !kill && ref_rise |=> !s_reg.lag)
    else $error("lag not low after reference rise");

  a_fall_lead: assert property (clk_en && s_reg.ctrl0.enable && !kill && ref_fall |=> !s_reg.lead)
    else $error("lead not low after reference fall");

  a_lead_gap: assert property (rise_gap_start ##1 gap_quiet |=> s_reg.lead)
    else $error("lead not set after one clock gap");

  a_lag_gap: assert property (fall_gap_start ##1 gap_quiet |=> s_reg.lag)
    else $error("lag not set after one clock gap");

  a_zero_gap: assert property (clk_en && s_reg.ctrl0.enable && !kill && ref_rise && s_reg.ctrl1.dead_code == 3'h0
                               |=> s_reg.lead)
    else $error("zero dead time still left a gap");

  a_edge_once: assert property (clk_en && ref_rise |=> !ref_rise)
    else $error("reference rise seen twice");

  a_kill_release: assert property (clk_en && $past(clk_en) && $fell(kill) |-> !lead_drive_pin && !lag_drive_pin)
    else $error("pins restored without disable time");

  // ---------------------------------------------------------------------------
  // interrupt assertions
  // ---------------------------------------------------------------------------
  a_irq_kill: assert property (clk_en && s_reg.ctrl0.irq_en && s_reg.ctrl0.irq_sel && kill_rise |=> irq)
    else $error("kill did not raise interrupt");

  a_irq_pulse: assert property (clk_en && irq |=> !irq)
    else $error("interrupt longer than one clock");

endmodule : pwmdb_core

`default_nettype wire

/* File: test/pwmdb_switch_model.sv */
`timescale 1ns/100ps
`default_nettype none

module pwmdb_switch_model (
  // gate drives from the block
  input  wire logic lead_drive_pin,
  input  wire logic lag_drive_pin,
  // what the switch pair saw
  output var  logic overlap_seen,
  output var  int   lead_rises,
  output var  int   rise_gap_ns
);
  realtime last_rise;

  initial begin
    overlap_seen = 1'b0;
    lead_rises   = 0;
    rise_gap_ns  = 0;
    last_rise    = 0.0;
  end

  // the gap between lead rises is the output period of the pair
  always @(posedge lead_drive_pin) begin
    rise_gap_ns = int'($realtime - last_rise);
    last_rise   = $realtime;
    lead_rises++;
  end

  // both switches on at once would short the supply
  always @(lead_drive_pin or lag_drive_pin) begin
    if (lead_drive_pin && lag_drive_pin) begin
      overlap_seen = 1'b1;
    end
  end
endmodule : pwmdb_switch_model

`default_nettype wire

/* File: test/pwm_dead_band_8bit_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module pwm_dead_band_8bit_tb_top;
  import pwmdb_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, clk_en, start, kill;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q1, q2;
  logic        pready, pslverr, lead, lag, irq, overlap_seen, bad;
  int          lead_rises, rise_gap_ns, irq_cnt, errors, checks_done, n0, n1;

  pwmdb_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_en(clk_en), .start(start), .kill(kill), .lead_drive_pin(lead), .lag_drive_pin(lag), .irq(irq));

  pwmdb_switch_model PAIR (.lead_drive_pin(lead), .lag_drive_pin(lag), .overlap_seen(overlap_seen),
    .lead_rises(lead_rises), .rise_gap_ns(rise_gap_ns));

  always #25 pclk = ~pclk;

  always @(posedge pclk) begin
    if (irq === 1'b1) begin
      irq_cnt++;
    end
  end

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // entered just after a rising edge, leaves one idle cycle behind
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    cmp("pslverr", 32'h0, {31'h0, pslverr});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd_cmp(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    cmp(what, e, q);
  endtask : rd_cmp

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; clk_en = 1'b1; start = 1'b1; kill = 1'b0;
    errors = 0; checks_done = 0; irq_cnt = 0;
    cyc(6);
    presetn <= 1'b1;
    cyc(1);
    rd_cmp("ctrl0", ADDR_CTRL0, 32'h0);
    rd_cmp("ctrl1", ADDR_CTRL1, 32'h0);
    rd_cmp("period", ADDR_PERIOD, 32'hff);
    rd_cmp("width", ADDR_WIDTH, 32'h7f);
    rd_cmp("unmapped", 8'h18, 32'h0);
    rd_cmp("status", ADDR_STATUS, 32'h0);
    cmp("pins stopped", {30'h0, lead, lag}, 32'h0);
    wr(ADDR_PERIOD, 32'h9);
    rd_cmp("count load", ADDR_COUNT, 32'h9);
    wr(ADDR_COUNT, 32'h3);
    rd_cmp("count ro", ADDR_COUNT, 32'h9);
    // run: period 9, width 4, one clock of dead band, irq on lead rise
    wr(ADDR_WIDTH, 32'h4);
    wr(ADDR_CTRL1, 32'h1);
    wr(ADDR_CTRL0, 32'h9);
    cyc(60);
    cmp("lead period ns", rise_gap_ns, 32'd500);
    cmp("overlap", {31'h0, overlap_seen}, 32'h0);
    cmp("irq on lead", {31'h0, irq_cnt != 0}, 32'h1);
    // start low must freeze the counter and the pins
    start <= 1'b0;
    cyc(3);
    n0 = lead_rises;
    apb(1'b0, ADDR_COUNT, 32'h0, q1);
    cyc(25);
    apb(1'b0, ADDR_COUNT, 32'h0, q2);
    cmp("frozen count", q2, q1);
    cmp("frozen rises", lead_rises, n0);
    start <= 1'b1;
    // width equal to period: lead held high once the reload picks it up
    wr(ADDR_WIDTH, 32'h9);
    cyc(30);
    bad = 1'b0;
    repeat (20) begin
      @(posedge pclk);
      bad = bad | (lead !== 1'b1) | (lag !== 1'b0);
    end
    cmp("width eq period", {31'h0, bad}, 32'h0);
    // kill gates the pins at once and raises the kill interrupt
    wr(ADDR_WIDTH, 32'h4);
    wr(ADDR_CTRL0, 32'hd);
    cyc(30);
    n1 = 0;
    while (lead !== 1'b1 && n1 < 40) begin
      n1++;
      @(posedge pclk);
    end
    cmp("lead before kill", {31'h0, lead}, 32'h1);
    irq_cnt = 0;
    n0 = lead_rises;
    kill <= 1'b1;
    #1;
    cmp("kill pins", {30'h0, lead, lag}, 32'h0);
    cyc(3);
    cmp("irq on kill", {31'h0, irq_cnt != 0}, 32'h1);
    kill <= 1'b0;
    cyc(40);
    cmp("sync restart", {31'h0, lead_rises > n0}, 32'h1);
    // free running mode: pins stay dark for a while after release, then recover
    wr(ADDR_CTRL1, 32'h11);
    kill <= 1'b1;
    cyc(3);
    kill <= 1'b0;
    n1 = lead_rises;
    #1;
    cmp("async hold", {30'h0, lead, lag}, 32'h0);
    cyc(40);
    cmp("async restart", {31'h0, lead_rises > n1}, 32'h1);
    // full stop mode: block stays off until software enables it again
    wr(ADDR_CTRL1, 32'h21);
    kill <= 1'b1;
    cyc(3);
    kill <= 1'b0;
    cyc(3);
    n0 = lead_rises;
    cyc(40);
    cmp("disabled rises", lead_rises, n0);
    wr(ADDR_CTRL0, 32'h1);
    cyc(40);
    cmp("reenabled", {31'h0, lead_rises > n0}, 32'h1);
    // programmable pulses: two shots, then the counter parks until a new start
    wr(ADDR_CTRL0, 32'h21);
    cyc(40);
    apb(1'b0, ADDR_STATUS, 32'h0, q1);
    cmp("ppg halted", q1 & 32'h8, 32'h8);
    apb(1'b0, ADDR_COUNT, 32'h0, q1);
    cyc(10);
    apb(1'b0, ADDR_COUNT, 32'h0, q2);
    cmp("ppg parked", q2, q1);
    wr(ADDR_CTRL0, 32'h21);
    apb(1'b0, ADDR_STATUS, 32'h0, q1);
    cmp("ppg restart", q1 & 32'h8, 32'h0);
    // hardware trigger: shots are not counted, the start pin alone runs it
    wr(ADDR_CTRL0, 32'h23);
    cyc(40);
    apb(1'b0, ADDR_STATUS, 32'h0, q1);
    cmp("hw trigger runs", q1 & 32'h8, 32'h0);
    wr(ADDR_CTRL0, 32'h0);
    cyc(2);
    cmp("pins stopped", {30'h0, lead, lag}, 32'h0);
    cmp("overlap", {31'h0, overlap_seen}, 32'h0);
    report_and_stop();
  end

  // the whole run needs well under 1000 cycles
  initial begin
    #250000;
    errors++;
    report_and_stop();
  end
endmodule : pwm_dead_band_8bit_tb_top

`default_nettype wire
